/* File: sbm_boot_handler.sv */
// Serial boot mode handler: program search, baud sync, block protocol, modes.
//
// Notes on behaviour
// - Region check starts at header base address.
// - Region length accepts any 16-bit count.
// - Spare region-check header byte is ignored.
// - Sum bytes from base through base plus length.
// - Reference bytes follow region at +1, +2.
// - Answer ack on match, else checksum error.
// - Execute mode jumps to header start address.
// - Execute mode ignores unused header bytes.
// - Execute mode ends all serial traffic.
// - Time zero test byte start to stop.
// - Derive 10-bit baud reload from count.
// - Frame eight data, two stop, then ack.
// - Store block in scratch; last byte checksum.
// - Bad block checksum answers checksum error.
// - Non-header block answers block error, flags.
// - Latch mode, address, length, block length.
// - Copy bytes to RAM, pointer increments.
// - Program found needs ID and checksum pass.
// - Search both sectors or second only.
// - Header is eight bytes with checksum.
// - Mode 02H selects region check.
// - Mode 03H selects execute from nonvolatile.
`timescale 1ns/1ns
`default_nettype none
`include "sbm_cfg.svh"
module sbm_boot_handler
	import sbm_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic search_both,
	input wire logic rxd,
	input wire logic [7:0] flash_rdata,
	output logic txd,
	output logic flash_rd,
	output logic [15:0] flash_addr,
	output logic ram_we,
	output logic [15:0] ram_write_pointer,
	output logic [7:0] ram_wdata,
	output logic jump,
	output logic jump_xram,
	output logic [15:0] jump_addr,
	output logic [9:0] baud_reload_value,
	output logic hdr_fail,
	output logic no_program
);
	// ------------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------------
	function automatic logic [14:0] bit_cycles(input logic [9:0] r);
		logic [14:0] w;
		w = {4'h0, 11'h400 - {1'b0, r}};
		return w << `SBM_BAUD_SHIFT;
	endfunction : bit_cycles

	function automatic logic [9:0] calc_reload(input logic [17:0] m);
		logic [17:0] d;
		d = m / (`SBM_SYNC_BITS << `SBM_BAUD_SHIFT);
		if (d > 18'd1024)
			d = 18'd1024;
		if (d == 18'h00000)
			d = 18'd1;
		return 10'(18'd1024 - d);
	endfunction : calc_reload

	function automatic logic [7:0] scr(input logic [7:0] i);
		return `SBM_SCR_BASE + i;
	endfunction : scr

	sbm_state_t state, ret;
	logic [7:0] scratch [`SBM_SCR_BASE:`SBM_SCR_TOP];
	logic tx_go, tx_busy, rx_en, rx_busy, rx_valid, ptr_load;
	logic [7:0] tx_byte, rx_data, rx_sh, bcnt, want, xacc, cidx, cnum;
	logic [9:0] tx_sh;
	logic [3:0] tx_bits, rx_bits;
	logic [14:0] tx_cnt, rx_cnt;
	logic [17:0] meas;
	logic expect_hdr, phase1, on_b, ck_ok;
	logic [7:0] mode, hdr_blk;
	logic [15:0] hdr_start, hdr_len, base, len;
	logic [16:0] fidx;
	logic [7:0] sum_add, sum_xor;
	logic cs_en;

	// ------------------------------------------------------------------------
	// Region checksum engine
	// ------------------------------------------------------------------------
	// Only the second wait cycle carries settled read data, so each byte is summed once.
	assign cs_en = (state == S_FWT) && !flash_rd && (fidx <= {1'b0, len});
	sbm_region_sum u_sum (
		.mclk(mclk),
		.rstn(rstn),
		.clr(state == S_CKSTART),
		.en(cs_en),
		.din(flash_rdata),
		.sum_add(sum_add),
		.sum_xor(sum_xor)
	);

	// ------------------------------------------------------------------------
	// Transmitter, 8 data bits, no parity, two stop bits
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			txd <= 1'b1;
			tx_busy <= 1'b0;
			tx_sh <= 10'h3ff;
			tx_bits <= 4'h0;
			tx_cnt <= 15'h0000;
		end
		else if (!tx_busy)
		begin
			if (tx_go)
			begin
				tx_sh <= {2'b11, tx_byte};
				txd <= 1'b0;
				tx_bits <= 4'd10;
				tx_cnt <= bit_cycles(baud_reload_value);
				tx_busy <= 1'b1;
			end
		end
		else if (tx_cnt == 15'h0001)
		begin
			if (tx_bits == 4'h0)
				tx_busy <= 1'b0;
			else
			begin
				txd <= tx_sh[0];
				tx_sh <= {1'b1, tx_sh[9:1]};
				tx_bits <= tx_bits - 4'h1;
				tx_cnt <= bit_cycles(baud_reload_value);
			end
		end
		else
			tx_cnt <= tx_cnt - 15'h0001;
	end

	// ------------------------------------------------------------------------
	// Receiver, sampling each bit in its middle
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			rx_busy <= 1'b0;
			rx_valid <= 1'b0;
			rx_bits <= 4'h0;
			rx_cnt <= 15'h0000;
			rx_sh <= 8'h00;
			rx_data <= 8'h00;
		end
		else
		begin
			rx_valid <= 1'b0;
			if (!rx_busy)
			begin
				if (rx_en && !rxd)
				begin
					rx_busy <= 1'b1;
					rx_bits <= 4'h0;
					rx_cnt <= bit_cycles(baud_reload_value) >> 1;
				end
			end
			else if (rx_cnt == 15'h0001)
			begin
				rx_cnt <= bit_cycles(baud_reload_value);
				rx_bits <= rx_bits + 4'h1;
				// A start bit gone high again is taken as noise.
				if (rx_bits == 4'h0 && rxd)
					rx_busy <= 1'b0;
				else if (rx_bits == 4'd9)
				begin
					rx_busy <= 1'b0;
					rx_valid <= rxd;
					rx_data <= rx_sh;
				end
				else if (rx_bits != 4'h0)
					rx_sh <= {rxd, rx_sh[7:1]};
			end
			else
				rx_cnt <= rx_cnt - 15'h0001;
		end
	end

	// ------------------------------------------------------------------------
	// RAM write pointer
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			ram_write_pointer <= 16'h0000;
		else if (ptr_load)
			ram_write_pointer <= hdr_start;
		else if (ram_we)
			ram_write_pointer <= ram_write_pointer + 16'h0001;
	end

	// ------------------------------------------------------------------------
	// Scratch buffer, written as bytes arrive
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk)
	begin
		if (state == S_RX && rx_valid && bcnt < `SBM_SCR_DEPTH)
			scratch[scr(bcnt)] <= rx_data;
	end

	// ------------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			state <= S_P1_START;
			ret <= S_RX;
			tx_go <= 1'b0;
			tx_byte <= 8'h00;
			rx_en <= 1'b0;
			ptr_load <= 1'b0;
			flash_rd <= 1'b0;
			flash_addr <= 16'h0000;
			ram_we <= 1'b0;
			ram_wdata <= 8'h00;
			jump <= 1'b0;
			jump_xram <= 1'b0;
			jump_addr <= 16'h0000;
			baud_reload_value <= 10'h000;
			hdr_fail <= 1'b0;
			no_program <= 1'b0;
			meas <= 18'h00000;
			bcnt <= 8'h00;
			want <= 8'h00;
			xacc <= 8'h00;
			cidx <= 8'h00;
			cnum <= 8'h00;
			expect_hdr <= 1'b1;
			mode <= 8'h00;
			hdr_blk <= 8'h00;
			hdr_start <= 16'h0000;
			hdr_len <= 16'h0000;
			base <= 16'h0000;
			len <= 16'h0000;
			fidx <= 17'h00000;
			phase1 <= 1'b1;
			on_b <= 1'b0;
			ck_ok <= 1'b0;
		end
		else
		begin
			tx_go <= 1'b0;
			ptr_load <= 1'b0;
			flash_rd <= 1'b0;
			ram_we <= 1'b0;
			case (state)
				S_P1_START:
				begin
					on_b <= !search_both;
					base <= search_both ? `SBM_SECT_A : `SBM_SECT_B;
					len <= `SBM_PROG_LEN;
					phase1 <= 1'b1;
					state <= S_CKSTART;
				end
				S_CKSTART:
				begin
					fidx <= 17'h00000;
					ck_ok <= 1'b1;
					state <= S_FRD;
				end
				S_FRD:
				begin
					flash_rd <= 1'b1;
					flash_addr <= base + fidx[15:0];
					state <= S_FWT;
				end
				S_FWT:
				begin
					// Read data is valid one cycle after the strobe.
					if (!flash_rd)
					begin
						if (phase1 && fidx == 17'h00000 && flash_rdata != `SBM_ID0)
							ck_ok <= 1'b0;
						if (phase1 && fidx == 17'h00001 && flash_rdata != `SBM_ID1)
							ck_ok <= 1'b0;
						if (fidx == {1'b0, len} + 17'h00001 && flash_rdata != sum_add)
							ck_ok <= 1'b0;
						if (fidx == {1'b0, len} + 17'h00002)
						begin
							if (flash_rdata != sum_xor)
								ck_ok <= 1'b0;
							state <= S_CKDONE;
						end
						else
						begin
							fidx <= fidx + 17'h00001;
							state <= S_FRD;
						end
					end
				end
				S_CKDONE:
				begin
					if (!phase1)
					begin
						tx_byte <= ck_ok ? `SBM_ACK : `SBM_CHK_ERR;
						tx_go <= 1'b1;
						expect_hdr <= 1'b1;
						ret <= S_RX;
						state <= S_TXW;
					end
					else if (ck_ok)
					begin
						jump <= 1'b1;
						jump_addr <= base;
						state <= S_DONE;
					end
					else if (!on_b)
					begin
						on_b <= 1'b1;
						base <= `SBM_SECT_B;
						state <= S_CKSTART;
					end
					else
					begin
						no_program <= 1'b1;
						state <= S_SYNC_IDLE;
					end
				end
				S_SYNC_IDLE:
					if (rxd)
						state <= S_SYNC_WAIT;
				S_SYNC_WAIT:
				begin
					// The first low sample already counts as one cycle of the test byte.
					meas <= 18'h00001;
					if (!rxd)
						state <= S_SYNC_MEAS;
				end
				S_SYNC_MEAS:
				begin
					// The all-zero test byte is low from start bit to stop bit.
					if (rxd)
						state <= S_SYNC_SET;
					else if (meas != `SBM_MEAS_MAX)
						meas <= meas + 18'h00001;
				end
				S_SYNC_SET:
				begin
					baud_reload_value <= calc_reload(meas);
					rx_en <= 1'b1;
					tx_byte <= `SBM_ACK;
					tx_go <= 1'b1;
					expect_hdr <= 1'b1;
					ret <= S_RX;
					state <= S_TXW;
				end
				S_TXW:
				begin
					bcnt <= 8'h00;
					xacc <= 8'h00;
					if (!tx_go && !tx_busy)
						state <= ret;
				end
				S_RX:
					if (rx_valid)
					begin
						if (bcnt == 8'h00)
						begin
							if (expect_hdr)
								want <= `SBM_HDR_LEN;
							else if (rx_data == `SBM_TYPE_EOT)
								want <= hdr_blk + 8'd3;
							else
								want <= hdr_blk + 8'd2;
						end
						xacc <= xacc ^ rx_data;
						bcnt <= bcnt + 8'h01;
						if (bcnt != 8'h00 && bcnt + 8'h01 == want)
							state <= S_RXDONE;
					end
				S_RXDONE:
				begin
					tx_go <= 1'b1;
					ret <= S_RX;
					state <= S_TXW;
					if (xacc != 8'h00)
						tx_byte <= `SBM_CHK_ERR;
					else if (expect_hdr && scratch[scr(`SBM_HF_TYPE)] != `SBM_TYPE_HDR)
					begin
						tx_byte <= `SBM_BLK_ERR;
						hdr_fail <= 1'b1;
					end
					else if (expect_hdr)
					begin
						// Only the trailing checksum byte of the header is never read here.
						mode <= scratch[scr(`SBM_HF_MODE)];
						hdr_start <= {scratch[scr(`SBM_HF_ADDR_HI)], scratch[scr(`SBM_HF_ADDR_LO)]};
						hdr_len <= {scratch[scr(`SBM_HF_LEN_HI)], scratch[scr(`SBM_HF_LEN_LO)]};
						hdr_blk <= scratch[scr(`SBM_HF_BLK)];
						hdr_fail <= 1'b0;
						tx_byte <= `SBM_ACK;
						ret <= S_DISP;
					end
					else if (scratch[scr(`SBM_HF_TYPE)] == `SBM_TYPE_DATA)
					begin
						tx_go <= 1'b0;
						cidx <= 8'd1;
						cnum <= hdr_blk;
						state <= S_COPY;
					end
					else if (scratch[scr(`SBM_HF_TYPE)] == `SBM_TYPE_EOT)
					begin
						tx_go <= 1'b0;
						cidx <= 8'd2;
						cnum <= scratch[scr(8'd1)];
						expect_hdr <= 1'b1;
						state <= S_COPY;
					end
					else
						tx_byte <= `SBM_BLK_ERR;
				end
				S_COPY:
					if (cnum == 8'h00)
					begin
						tx_byte <= `SBM_ACK;
						tx_go <= 1'b1;
						ret <= S_RX;
						state <= S_TXW;
					end
					else
					begin
						ram_we <= 1'b1;
						ram_wdata <= scratch[scr(cidx)];
						cidx <= cidx + 8'h01;
						cnum <= cnum - 8'h01;
					end
				S_DISP:
				begin
					bcnt <= 8'h00;
					xacc <= 8'h00;
					state <= S_RX;
					case (mode)
						`SBM_MODE_LOAD:
						begin
							ptr_load <= 1'b1;
							expect_hdr <= 1'b0;
						end
						`SBM_MODE_RUN_RAM:
						begin
							jump <= 1'b1;
							jump_xram <= 1'b1;
							jump_addr <= hdr_start;
							state <= S_DONE;
						end
						`SBM_MODE_CHECK:
						begin
							base <= hdr_start;
							len <= hdr_len;
							phase1 <= 1'b0;
							state <= S_CKSTART;
						end
						`SBM_MODE_RUN_NVM:
						begin
							jump <= 1'b1;
							jump_addr <= hdr_start;
							state <= S_DONE;
						end
						default:
							expect_hdr <= 1'b1;
					endcase
				end
				S_DONE:
					state <= S_DONE;
				default:
					state <= S_P1_START;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	a_ptr_step:
	assert property (@(posedge mclk) disable iff (!rstn)
		ram_we && !ptr_load |=> ram_write_pointer == $past(ram_write_pointer) + 16'h0001)
		else $error("RAM pointer did not step after a write");

	a_sync_ack:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_SYNC_SET |=> tx_go && tx_byte == `SBM_ACK && rx_en)
		else $error("No acknowledge after baud sync");

	a_stop_bits:
	assert property (@(posedge mclk) disable iff (!rstn)
		$fell(tx_busy) |-> txd && $past(txd, 2))
		else $error("Frame did not end in stop level");

	a_chk_err:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_RXDONE && xacc != 8'h00 |=> tx_go && tx_byte == `SBM_CHK_ERR)
		else $error("Bad block checksum not reported");

	a_blk_err:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_RXDONE && xacc == 8'h00 && expect_hdr && scratch[scr(`SBM_HF_TYPE)] != `SBM_TYPE_HDR
		|=> tx_byte == `SBM_BLK_ERR && hdr_fail)
		else $error("Wrong header type not reported");

	a_ref_addr:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_FRD && fidx == {1'b0, len} + 17'h00002 |=> flash_addr == base + len + 16'h0002)
		else $error("Second reference byte read from wrong address");

	a_region_ans:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_CKDONE && !phase1 |=> tx_go && (tx_byte == `SBM_ACK) == $past(ck_ok))
		else $error("Region verdict does not match comparison");

	a_run_nvm:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_DISP && mode == `SBM_MODE_RUN_NVM |=> jump && !jump_xram && jump_addr == $past(hdr_start))
		else $error("Execute mode jumped to wrong address");

	a_silent_end:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_DONE |-> !tx_go ##1 !tx_go)
		else $error("Serial traffic after program jump");

	a_first_addr:
	assert property (@(posedge mclk) disable iff (!rstn)
		state == S_CKSTART && !phase1 ##1 state == S_FRD |=> flash_addr == base)
		else $error("Region check did not start at base");
endmodule : sbm_boot_handler
`default_nettype wire

/* File: sbm_cfg.svh */
// Constants of the serial boot mode handler: codes, offsets, layout and timing.
`ifndef SBM_CFG_SVH
`define SBM_CFG_SVH

// ----------------------------------------------------------------------------
// Answer codes and block types
// ----------------------------------------------------------------------------
`define SBM_ACK 8'h55
`define SBM_BLK_ERR 8'hff
`define SBM_CHK_ERR 8'hfe
`define SBM_TYPE_HDR 8'h00
`define SBM_TYPE_DATA 8'h01
`define SBM_TYPE_EOT 8'h02

// ----------------------------------------------------------------------------
// Working modes
// ----------------------------------------------------------------------------
`define SBM_MODE_LOAD 8'h00
`define SBM_MODE_RUN_RAM 8'h01
`define SBM_MODE_CHECK 8'h02
`define SBM_MODE_RUN_NVM 8'h03

// ----------------------------------------------------------------------------
// Header layout, byte offsets inside the block
// ----------------------------------------------------------------------------
`define SBM_HDR_LEN 8'd8
`define SBM_HF_TYPE 8'd0
`define SBM_HF_MODE 8'd1
`define SBM_HF_ADDR_HI 8'd2
`define SBM_HF_ADDR_LO 8'd3
`define SBM_HF_LEN_HI 8'd4
`define SBM_HF_LEN_LO 8'd5
`define SBM_HF_BLK 8'd6

// ----------------------------------------------------------------------------
// Scratch buffer span
// ----------------------------------------------------------------------------
`define SBM_SCR_BASE 8'h70
`define SBM_SCR_TOP 8'hff
`define SBM_SCR_DEPTH 8'd144

// ----------------------------------------------------------------------------
// Baud measurement
// ----------------------------------------------------------------------------
`define SBM_SYNC_BITS 18'd9
`define SBM_BAUD_SHIFT 4
`define SBM_MEAS_MAX 18'h3ffff

// ----------------------------------------------------------------------------
// Resident program search
// ----------------------------------------------------------------------------
`define SBM_SECT_A 16'h0200
`define SBM_SECT_B 16'h8000
`define SBM_PROG_LEN 16'h00ff
// Identification byte values are arbitrary.
`define SBM_ID0 8'ha5
`define SBM_ID1 8'h5a

`endif

/* File: sbm_pkg.sv */
// Types of the serial boot mode handler.
package sbm_pkg;
	typedef enum logic [3:0] {
		S_P1_START, S_CKSTART, S_FRD, S_FWT, S_CKDONE,
		S_SYNC_IDLE, S_SYNC_WAIT, S_SYNC_MEAS, S_SYNC_SET,
		S_RX, S_RXDONE, S_DISP, S_COPY, S_TXW, S_DONE
	} sbm_state_t;
endpackage : sbm_pkg

/* File: sbm_region_sum.sv */
// Replaceable two-byte checksum engine over a stream of memory bytes.
`timescale 1ns/1ns
`default_nettype none
// Default: first byte is the sum modulo 256, second is the XOR of all bytes.
module sbm_region_sum
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic clr,
	input wire logic en,
	input wire logic [7:0] din,
	output logic [7:0] sum_add,
	output logic [7:0] sum_xor
);
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			sum_add <= 8'h00;
			sum_xor <= 8'h00;
		end
		else if (clr)
		begin
			sum_add <= 8'h00;
			sum_xor <= 8'h00;
		end
		else if (en)
		begin
			sum_add <= sum_add + din;
			sum_xor <= sum_xor ^ din;
		end
	end
endmodule : sbm_region_sum
`default_nettype wire

/* File: sbm_host_model.sv */
// Host computer model for the serial boot link: block sender and answer monitor.
`timescale 1ns/1ns
`default_nettype none
module sbm_host_model
#(
	parameter int BIT_CYC = 32
)
(
	input wire logic mclk,
	input wire logic txd,
	output logic rxd
);
	logic [7:0] rx_q[$];
	int bad_frames = 0;

	initial rxd = 1'b1;

	// Each bit is held for the whole bit time; the line rests high between frames.
	task automatic send_byte(input logic [7:0] b);
		logic [10:0] fr;
		fr = {2'b11, b, 1'b0};
		for (int i = 0; i < 11; i++)
		begin
			@(negedge mclk);
			rxd = fr[i];
			repeat (BIT_CYC - 1) @(negedge mclk);
		end
	endtask : send_byte

	// The checksum byte is appended here; bad flips it to provoke a refusal.
	task automatic send_block(input logic [7:0] q[$], input logic bad);
		logic [7:0] x;
		x = 8'h00;
		foreach (q[i])
		begin
			send_byte(q[i]);
			x = x ^ q[i];
		end
		send_byte(x ^ {7'h00, bad});
	endtask : send_block

	task automatic send_header(input logic [7:0] typ, input logic [7:0] mode, input logic [15:0] addr,
		input logic [15:0] len, input logic [7:0] spare, input logic bad);
		send_block('{typ, mode, addr[15:8], addr[7:0], len[15:8], len[7:0], spare}, bad);
	endtask : send_header

	// ------------------------------------------------------------------------
	// Answer monitor
	// ------------------------------------------------------------------------
	// Samples mid-bit, so it tolerates an answer that starts during our stop bits.
	always
	begin
		logic [7:0] b;
		@(negedge txd);
		repeat (BIT_CYC / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (BIT_CYC) @(posedge mclk);
			b[i] = txd;
		end
		for (int i = 0; i < 2; i++)
		begin
			repeat (BIT_CYC) @(posedge mclk);
			if (txd !== 1'b1)
				bad_frames++;
		end
		rx_q.push_back(b);
	end
endmodule : sbm_host_model
`default_nettype wire

/* File: serial_boot_mode_handler_test.sv */
// Self-checking testbench of the serial boot mode handler.
`timescale 1ns/1ns
`default_nettype none
`include "sbm_cfg.svh"
module serial_boot_mode_handler_test;
	localparam int BIT_CYC = 32;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic search_both = 1'b1;
	logic rxd;
	logic [7:0] flash_rdata = 8'h00;
	logic txd, flash_rd, ram_we, jump, jump_xram, hdr_fail, no_program;
	logic [15:0] flash_addr, ram_write_pointer, jump_addr;
	logic [7:0] ram_wdata;
	logic [9:0] baud_reload_value;
	logic [7:0] mem [0:65535];
	logic [23:0] ram_q[$];
	int err_count = 0;
	int samples_checked = 0;

	always #5 mclk = ~mclk;

	sbm_boot_handler dut_u (.mclk(mclk), .rstn(rstn), .search_both(search_both), .rxd(rxd),
		.flash_rdata(flash_rdata), .txd(txd), .flash_rd(flash_rd), .flash_addr(flash_addr),
		.ram_we(ram_we), .ram_write_pointer(ram_write_pointer), .ram_wdata(ram_wdata), .jump(jump),
		.jump_xram(jump_xram), .jump_addr(jump_addr), .baud_reload_value(baud_reload_value),
		.hdr_fail(hdr_fail), .no_program(no_program));

	sbm_host_model #(.BIT_CYC(BIT_CYC)) host_u (.mclk(mclk), .txd(txd), .rxd(rxd));

	// Read data changes at the falling edge, so it is settled for the next rising edge.
	always @(negedge mclk)
		flash_rdata <= mem[flash_addr];

	always @(posedge mclk)
		if (ram_we === 1'b1)
			ram_q.push_back({ram_write_pointer, ram_wdata});

	// ------------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic expect_byte(input string what, input logic [7:0] exp);
		int n;
		n = 0;
		while (host_u.rx_q.size() == 0 && n < 20000)
		begin
			@(posedge mclk);
			n++;
		end
		if (host_u.rx_q.size() == 0)
			check(what, 16'h0100, {8'h00, exp});
		else
			check(what, {8'h00, host_u.rx_q.pop_front()}, {8'h00, exp});
	endtask : expect_byte

	task automatic wait_high(ref logic sig, input int limit);
		for (int n = 0; n < limit && sig !== 1'b1; n++)
			@(posedge mclk);
	endtask : wait_high

	task automatic do_reset(input logic both);
		@(negedge mclk);
		rstn = 1'b0;
		search_both = both;
		repeat (20) @(negedge mclk);
		rstn = 1'b1;
	endtask : do_reset

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_search_fail();
		wait_high(no_program, 4000);
		check("no_program", {15'h0, no_program}, 16'h0001);
		check("jump", {15'h0, jump}, 16'h0000);
		$display("test search_fail done");
	endtask : t_search_fail

	// A bit time of 32 cycles gives a count of 288, so the reload is 1024 - 2.
	task automatic t_sync();
		host_u.send_byte(8'h00);
		expect_byte("sync ack", `SBM_ACK);
		check("baud_reload_value", {6'h0, baud_reload_value}, 16'h03fe);
		$display("test sync done");
	endtask : t_sync

	task automatic t_hdr_errors();
		host_u.send_header(`SBM_TYPE_HDR, `SBM_MODE_CHECK, 16'h1000, 16'h0003, 8'h00, 1'b1);
		expect_byte("bad checksum", `SBM_CHK_ERR);
		host_u.send_header(`SBM_TYPE_DATA, `SBM_MODE_CHECK, 16'h1000, 16'h0003, 8'h00, 1'b0);
		expect_byte("wrong type", `SBM_BLK_ERR);
		check("hdr_fail", {15'h0, hdr_fail}, 16'h0001);
		host_u.send_header(`SBM_TYPE_HDR, 8'h07, 16'h1000, 16'h0003, 8'h00, 1'b0);
		expect_byte("unknown mode", `SBM_ACK);
		$display("test hdr_errors done");
	endtask : t_hdr_errors

	// Default region sum: sum modulo 256 then XOR, over base through base plus length.
	task automatic t_mode2(input logic [15:0] base, input logic [15:0] len, input logic [7:0] spare,
		input logic bad);
		logic [7:0] s, x;
		s = 8'h00;
		x = 8'h00;
		for (int i = 0; i <= len; i++)
		begin
			mem[16'(base + i)] = 8'(i * 7 + 3);
			s = s + 8'(i * 7 + 3);
			x = x ^ 8'(i * 7 + 3);
		end
		mem[16'(base + len + 1)] = s;
		mem[16'(base + len + 2)] = x ^ {7'h00, bad};
		host_u.send_header(`SBM_TYPE_HDR, `SBM_MODE_CHECK, base, len, spare, 1'b0);
		expect_byte("mode2 header", `SBM_ACK);
		check("hdr_fail clear", {15'h0, hdr_fail}, 16'h0000);
		expect_byte("mode2 answer", bad ? `SBM_CHK_ERR : `SBM_ACK);
		$display("test mode2 done");
	endtask : t_mode2

	task automatic t_mode0();
		logic [23:0] exp_q[$];
		exp_q = '{24'hf400a1, 24'hf401b2, 24'hf402c3};
		host_u.send_header(`SBM_TYPE_HDR, `SBM_MODE_LOAD, 16'hf400, 16'h0000, 8'h02, 1'b0);
		expect_byte("mode0 header", `SBM_ACK);
		host_u.send_block('{`SBM_TYPE_DATA, 8'ha1, 8'hb2}, 1'b0);
		expect_byte("data block", `SBM_ACK);
		host_u.send_block('{`SBM_TYPE_EOT, 8'h01, 8'hc3, 8'hd4}, 1'b0);
		expect_byte("eot block", `SBM_ACK);
		check("ram writes", 16'(ram_q.size()), 16'd3);
		foreach (exp_q[i])
			check("ram write", ram_q.size() > i ? ram_q[i][15:0] : 16'h0, exp_q[i][15:0]);
		foreach (exp_q[i])
			check("ram addr", ram_q.size() > i ? ram_q[i][23:8] : 16'h0, exp_q[i][23:8]);
		$display("test mode0 done");
	endtask : t_mode0

	task automatic t_mode3();
		int low;
		low = 0;
		host_u.send_header(`SBM_TYPE_HDR, `SBM_MODE_RUN_NVM, 16'h1234, 16'hbeef, 8'h77, 1'b0);
		expect_byte("mode3 header", `SBM_ACK);
		wait_high(jump, 2000);
		check("jump", {15'h0, jump}, 16'h0001);
		check("jump_addr", jump_addr, 16'h1234);
		check("jump_xram", {15'h0, jump_xram}, 16'h0000);
		repeat (20 * BIT_CYC)
		begin
			@(posedge mclk);
			if (txd !== 1'b1)
				low++;
		end
		check("silent after jump", 16'(low), 16'd0);
		$display("test mode3 done");
	endtask : t_mode3

	// Mode 3 ended the run, so mode 1 gets a fresh reset, a failed search and a new sync.
	task automatic t_mode1();
		foreach (mem[i])
			mem[i] = 8'h00;
		do_reset(1'b0);
		wait_high(no_program, 4000);
		check("mode1 no_program", {15'h0, no_program}, 16'h0001);
		t_sync();
		host_u.send_header(`SBM_TYPE_HDR, `SBM_MODE_RUN_RAM, 16'hf420, 16'h0000, 8'h00, 1'b0);
		expect_byte("mode1 header", `SBM_ACK);
		wait_high(jump, 2000);
		check("mode1 jump_xram", {15'h0, jump_xram}, 16'h0001);
		check("mode1 jump_addr", jump_addr, 16'hf420);
		$display("test mode1 done");
	endtask : t_mode1

	// Both sectors hold a valid program; only the selection decides which one runs.
	task automatic t_search_pass();
		foreach (mem[i])
			mem[i] = 8'h00;
		for (int k = 0; k < 2; k++)
		begin
			mem[16'h0200 + 16'(k * 16'h7e00)] = 8'ha5;
			mem[16'h0201 + 16'(k * 16'h7e00)] = 8'h5a;
			mem[16'h0300 + 16'(k * 16'h7e00)] = 8'hff;
			mem[16'h0301 + 16'(k * 16'h7e00)] = 8'hff;
		end
		for (int k = 0; k < 2; k++)
		begin
			do_reset(k[0]);
			wait_high(jump, 4000);
			check("found jump", {15'h0, jump}, 16'h0001);
			check("found addr", jump_addr, k ? 16'h0200 : 16'h8000);
		end
		$display("test search_pass done");
	endtask : t_search_pass

	initial
	begin
		repeat (60000) @(posedge mclk);
		err_count++;
		finish_test();
	end

	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
		do_reset(1'b1);
		t_search_fail();
		t_sync();
		t_hdr_errors();
		t_mode2(16'h1000, 16'h0003, 8'h5a, 1'b0);
		t_mode2(16'h2000, 16'h0000, 8'hc3, 1'b1);
		t_mode0();
		t_mode3();
		check("answer framing", 16'(host_u.bad_frames), 16'd0);
		t_mode1();
		t_search_pass();
		finish_test();
	end
endmodule : serial_boot_mode_handler_test
`default_nettype wire
